// file: design/mrt_byte_store.sv
// Purpose: writable threshold and checksum bytes with registered read port
// Assumes: write enable already qualified by access level
// Notes:   checksum is plain storage, never computed here
`timescale 1ns/1ps
`default_nettype none
module mrt_byte_store
  import mrt_pkg::*;
(
  input wire logic   core_clk,
  input wire logic   rst_n,
  mrt_store_if.store bus
);
  typedef struct packed {
    logic [7:0] threshHi;
    logic [7:0] threshLo;
    logic [7:0] checksum;
    logic [7:0] rdData;
  } mrt_store_s;

  localparam mrt_store_s STORE_RST = '{
    threshHi: RST_RX_LOW_HI,
    threshLo: RST_RX_LOW_LO,
    checksum: RST_CHECKSUM,
    rdData:   UNMAPPED_VALUE
  };

  mrt_store_s s_reg;
  mrt_store_s s_next;

  always_comb begin
    s_next = s_reg;
    if (bus.wrEn) begin
      if (bus.addr == OFF_RX_LOW_HI) begin
        s_next.threshHi = bus.wrData;
      end else if (bus.addr == OFF_RX_LOW_LO) begin
        s_next.threshLo = bus.wrData;
      end else if (bus.addr == OFF_CHECKSUM) begin
        s_next.checksum = bus.wrData;
      end
    end
    if (bus.addr == OFF_RX_LOW_HI) begin
      s_next.rdData = s_reg.threshHi;
    end else if (bus.addr == OFF_RX_LOW_LO) begin
      s_next.rdData = s_reg.threshLo;
    end else if (bus.addr == OFF_CHECKSUM) begin
      s_next.rdData = s_reg.checksum;
    end else begin
      s_next.rdData = UNMAPPED_VALUE;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= STORE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.rdData   = s_reg.rdData;
  assign bus.threshHi = s_reg.threshHi;
endmodule
`default_nettype wire

// file: design/mrt_regs_top.sv
// Purpose: two-wire slave for the receive low warning, checksum and result bytes
// Assumes: converter delivers result high bytes with a one-cycle valid pulse
// Notes:   password check lives elsewhere; its level arrives on a port
`timescale 1ns/1ps
`default_nettype none
module mrt_regs_top
  import mrt_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output var  logic       sdaOut,
  output var  logic       sdaOe,
  input  wire logic       privilegedPasswordLevel,
  input  wire logic [7:0] receivedPowerResultHi,
  input  wire logic [7:0] tempSample,
  input  wire logic [7:0] voltSample,
  input  wire logic       sampleValid,
  output var  logic       warningFlag
);
  typedef struct packed {
    logic [SYNC_DEPTH-1:0] sclSync;
    logic [SYNC_DEPTH-1:0] sdaSync;
    logic                  sclF;
    logic                  sdaF;
    mrt_state_e            st;
    mrt_phase_e            phase;
    logic [3:0]            bitCnt;
    logic [7:0]            shift;
    logic                  isRead;
    logic [7:0]            ptr;
    logic                  wrEn;
    logic [7:0]            wrData;
    logic [7:0]            wrAddr;
    logic                  oe;
    logic                  out;
    logic                  warn;
    logic [7:0]            tempHi;
    logic [7:0]            voltHi;
  } mrt_core_s;

  localparam mrt_core_s CORE_RST = '{
    sclSync: '1,
    sdaSync: '1,
    sclF:    1'b1,
    sdaF:    1'b1,
    st:      ST_IDLE,
    phase:   PH_ADDR,
    bitCnt:  4'h0,
    shift:   8'h00,
    isRead:  1'b0,
    ptr:     8'h00,
    wrEn:    1'b0,
    wrData:  8'h00,
    wrAddr:  8'h00,
    oe:      1'b0,
    out:     1'b0,
    warn:    1'b0,
    tempHi:  RST_TEMP_HI,
    voltHi:  RST_VOLT_HI
  };

  mrt_core_s   c_reg;
  mrt_core_s   c_next;
  mrt_store_if sif ();

  mrt_byte_store u_store (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .bus      (sif.store)
  );

  // Store sees the pointer for reads, the latched address for writes
  assign sif.wrEn   = c_reg.wrEn;
  assign sif.wrData = c_reg.wrData;
  assign sif.addr   = c_reg.wrEn ? c_reg.wrAddr : c_reg.ptr;

  logic       sclNew;
  logic       sdaNew;
  logic       sclRise;
  logic       sclFall;
  logic       startSeen;
  logic       stopSeen;
  logic [7:0] rdByte;
  logic       writable;

  // Read mux on the current pointer
  always_comb begin
    if (c_reg.ptr == OFF_TEMP_HI) begin
      rdByte = c_reg.tempHi;
    end else if (c_reg.ptr == OFF_TEMP_LO) begin
      rdByte = LO_RESULT_VALUE;
    end else if (c_reg.ptr == OFF_VOLT_HI) begin
      rdByte = c_reg.voltHi;
    end else if (c_reg.ptr == OFF_VOLT_LO) begin
      rdByte = LO_RESULT_VALUE;
    end else begin
      rdByte = sif.rdData;
    end
  end

  // Result bytes are never writable; checksum only at privileged level
  always_comb begin
    if (c_reg.ptr == OFF_RX_LOW_HI || c_reg.ptr == OFF_RX_LOW_LO) begin
      writable = 1'b1;
    end else if (c_reg.ptr == OFF_CHECKSUM) begin
      writable = privilegedPasswordLevel;
    end else begin
      writable = 1'b0;
    end
  end

  always_comb begin
    c_next    = c_reg;
    sclNew    = c_reg.sclF;
    sdaNew    = c_reg.sdaF;
    sclRise   = 1'b0;
    sclFall   = 1'b0;
    startSeen = 1'b0;
    stopSeen  = 1'b0;

    c_next.sclSync = {c_reg.sclSync[SYNC_DEPTH-2:0], sclIn};
    c_next.sdaSync = {c_reg.sdaSync[SYNC_DEPTH-2:0], sdaIn};
    // Change taken only when second and third stages agree
    if (c_reg.sclSync[1] == c_reg.sclSync[2]) begin
      sclNew = c_reg.sclSync[2];
    end
    if (c_reg.sdaSync[1] == c_reg.sdaSync[2]) begin
      sdaNew = c_reg.sdaSync[2];
    end
    c_next.sclF = sclNew;
    c_next.sdaF = sdaNew;
    sclRise   = sclNew & ~c_reg.sclF;
    sclFall   = ~sclNew & c_reg.sclF;
    startSeen = c_reg.sclF & sclNew & c_reg.sdaF & ~sdaNew;
    stopSeen  = c_reg.sclF & sclNew & ~c_reg.sdaF & sdaNew;

    c_next.wrEn = 1'b0;
    c_next.warn = receivedPowerResultHi < sif.threshHi;
    // Low bytes never enter the compare
    if (sampleValid) begin
      c_next.tempHi = tempSample;
      c_next.voltHi = voltSample;
    end

    if (startSeen) begin
      c_next.st     = ST_RX;
      c_next.phase  = PH_ADDR;
      c_next.bitCnt = 4'h0;
      c_next.oe     = 1'b0;
    end else if (stopSeen) begin
      c_next.st = ST_IDLE;
      c_next.oe = 1'b0;
    end else begin
      case (c_reg.st)
        ST_IDLE: begin
          c_next.oe = 1'b0;
        end
        ST_RX: begin
          if (sclRise) begin
            c_next.shift  = {c_reg.shift[6:0], sdaNew};
            c_next.bitCnt = c_reg.bitCnt + 4'h1;
          end else if (sclFall && c_reg.bitCnt == BITS_PER_BYTE) begin
            c_next.st = ST_ACK;
            c_next.oe = 1'b1;
            if (c_reg.phase == PH_ADDR) begin
              c_next.isRead = c_reg.shift[0];
              if (c_reg.shift[7:1] != DEV_ADDR) begin
                c_next.st = ST_IDLE;
                c_next.oe = 1'b0;
              end
            end else if (c_reg.phase == PH_PTR) begin
              c_next.ptr = c_reg.shift;
            end else begin
              // Ignored writes still get an acknowledge
              c_next.wrEn   = writable;
              c_next.wrAddr = c_reg.ptr;
              c_next.wrData = c_reg.shift;
              c_next.ptr    = c_reg.ptr + 8'h01;
            end
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            c_next.oe = 1'b0;
            if (c_reg.isRead && c_reg.phase == PH_ADDR) begin
              c_next.st     = ST_TX;
              c_next.shift  = rdByte;
              c_next.oe     = ~rdByte[7];
              c_next.bitCnt = 4'h1;
              c_next.ptr    = c_reg.ptr + 8'h01;
            end else begin
              c_next.st     = ST_RX;
              c_next.bitCnt = 4'h0;
              c_next.phase  = (c_reg.phase == PH_ADDR) ? PH_PTR : PH_DATA;
            end
          end
        end
        ST_TX: begin
          if (sclFall) begin
            if (c_reg.bitCnt == BITS_PER_BYTE) begin
              c_next.st = ST_TXACK;
              c_next.oe = 1'b0;
            end else begin
              c_next.oe     = ~c_reg.shift[6];
              c_next.shift  = {c_reg.shift[6:0], 1'b0};
              c_next.bitCnt = c_reg.bitCnt + 4'h1;
            end
          end
        end
        ST_TXACK: begin
          // Master not acknowledging ends the read
          if (sclRise && sdaNew) begin
            c_next.st = ST_IDLE;
          end else if (sclFall) begin
            c_next.st     = ST_TX;
            c_next.shift  = rdByte;
            c_next.oe     = ~rdByte[7];
            c_next.bitCnt = 4'h1;
            c_next.ptr    = c_reg.ptr + 8'h01;
          end
        end
        default: begin
          c_next.st = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      c_reg <= CORE_RST;
    end else begin
      c_reg <= c_next;
    end
  end

  // Open drain: pin only ever pulled low
  assign sdaOut      = c_reg.out;
  assign sdaOe       = c_reg.oe;
  assign warningFlag = c_reg.warn;
endmodule
`default_nettype wire

// file: dv/monitor_result_threshold_regs_tb_top.sv
// Purpose: self-checking bench for the monitor result byte slice
// Assumes: host model paces the bus, 200 MHz clock
// Notes:   threshold high byte is left at 0x40 by the row table
`timescale 1ns/1ps
`default_nettype none
module monitor_result_threshold_regs_tb_top;
  import mrt_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] wd; logic pv; logic [7:0] ex;} mrt_row_s;
  logic       core_clk = 1'b0;
  logic       rst_n    = 1'b0;
  logic       privLvl  = 1'b0;
  logic       sampleValid = 1'b0;
  logic [7:0] power    = 8'h00;
  logic [7:0] tempS    = 8'h00;
  logic [7:0] voltS    = 8'h00;
  logic [7:0] q;
  logic       k;
  wire logic  scl;
  wire logic  sdaRel;
  wire logic  sdaLine;
  logic       sdaOut;
  logic       sdaOe;
  logic       warningFlag;
  int         num_errors  = 0;
  int         comparisons = 0;
  mrt_row_s rows[9] = '{'{OFF_RX_LOW_HI, 8'h40, 1'b0, 8'h40}, '{OFF_RX_LOW_LO, 8'h5A, 1'b0, 8'h5A},
    '{OFF_CHECKSUM, 8'hC3, 1'b1, 8'hC3}, '{OFF_CHECKSUM, 8'h11, 1'b0, 8'hC3}, '{OFF_TEMP_HI, 8'h77, 1'b0, 8'h00},
    '{OFF_TEMP_LO, 8'h55, 1'b0, 8'h00}, '{OFF_VOLT_HI, 8'h66, 1'b0, 8'h00}, '{OFF_VOLT_LO, 8'h44, 1'b0, 8'h00},
    '{8'h80, 8'h99, 1'b1, UNMAPPED_VALUE}};
  logic [7:0] pw[5]  = '{8'h3F, 8'h40, 8'hFF, 8'h00, 8'h41};
  logic [7:0] res[4] = '{8'h19, 8'h00, 8'h85, 8'h00};
  assign sdaLine = sdaRel & ~sdaOe;
  mrt_host_model host (.core_clk(core_clk), .sdaLine(sdaLine), .sclOut(scl), .sdaRel(sdaRel));
  mrt_regs_top DUT (.core_clk(core_clk), .rst_n(rst_n), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .privilegedPasswordLevel(privLvl), .receivedPowerResultHi(power), .tempSample(tempS),
    .voltSample(voltS), .sampleValid(sampleValid), .warningFlag(warningFlag));
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] ex);
    comparisons++;
    if (got !== ex) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, ex);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    logic       n;
    logic       ak;
    host.start();
    host.xb(8'hA2, 1'b1, x, ak);
    host.xb(a, 1'b1, x, n);
    ak |= n;
    host.xb(d, 1'b1, x, n);
    host.stop();
    chk({7'h00, ak | n}, 8'h00);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic n;
    host.start();
    host.xb(8'hA2, 1'b1, d, n);
    host.xb(a, 1'b1, d, n);
    host.start();
    host.xb(8'hA3, 1'b1, d, n);
    // Last byte of a read is refused by the master
    host.xb(8'hFF, 1'b1, d, n);
    host.stop();
  endtask
  task automatic conclude();
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #250us;
    num_errors++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    foreach (rows[i]) begin
      privLvl <= rows[i].pv;
      wr(rows[i].a, rows[i].wd);
      rd(rows[i].a, q);
      chk(q, rows[i].ex);
    end
    // Low threshold byte is nonzero, so 0x40 also shows it is ignored
    foreach (pw[i]) begin
      power <= pw[i];
      repeat (3) @(posedge core_clk);
      chk({7'h00, warningFlag}, {7'h00, pw[i] < 8'h40});
    end
    wr(OFF_RX_LOW_LO, 8'h00);
    tempS <= 8'h19;
    voltS <= 8'h85;
    sampleValid <= 1'b1;
    @(posedge core_clk);
    sampleValid <= 1'b0;
    tempS <= 8'hEE;
    voltS <= 8'hEE;
    wr(OFF_TEMP_HI, 8'hAA);
    foreach (res[i]) begin
      rd(8'(OFF_TEMP_HI + i), q);
      chk(q, res[i]);
    end
    host.start();
    host.xb(8'hA4, 1'b1, q, k);
    host.stop();
    chk({7'h00, k}, 8'h01);
    rst_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    rd(OFF_RX_LOW_HI, q);
    chk(q, RST_RX_LOW_HI);
    rd(OFF_CHECKSUM, q);
    chk(q, RST_CHECKSUM);
    rd(OFF_TEMP_HI, q);
    chk(q, RST_TEMP_HI);
    conclude();
  end
endmodule
`default_nettype wire

// file: dv/mrt_host_model.sv
// Purpose: two-wire bus master standing in for the host controller
// Assumes: open-drain line resolved by the bench, scl high phase 10 clocks, low phase 12 clocks
// Notes:   tasks are called from the bench
`timescale 1ns/1ps
`default_nettype none
module mrt_host_model (
  input  wire logic core_clk,
  input  wire logic sdaLine,
  output var  logic sclOut,
  output var  logic sdaRel
);
  initial begin
    sclOut = 1'b1;
    sdaRel = 1'b1;
  end
  task automatic hp();
    repeat (10) @(posedge core_clk);
  endtask
  // Gap after scl fall so data never moves with the clock edge
  task automatic bitx(input logic b, output logic r);
    repeat (2) @(posedge core_clk);
    sdaRel <= b;
    hp();
    sclOut <= 1'b1;
    hp();
    r = sdaLine;
    sclOut <= 1'b0;
  endtask
  task automatic start();
    repeat (2) @(posedge core_clk);
    sdaRel <= 1'b1;
    hp();
    sclOut <= 1'b1;
    hp();
    sdaRel <= 1'b0;
    hp();
    sclOut <= 1'b0;
  endtask
  task automatic stop();
    repeat (2) @(posedge core_clk);
    sdaRel <= 1'b0;
    hp();
    sclOut <= 1'b1;
    hp();
    sdaRel <= 1'b1;
    hp();
  endtask
  // Ninth bit: ab=1 releases for the device, ab=0 acknowledges a read
  task automatic xb(input logic [7:0] d, input logic ab, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[i]);
    end
    bitx(ab, k);
  endtask
endmodule
`default_nettype wire

// file: dv/mrt_regs_chk.sv
// Purpose: port level checks for the monitor result byte slice
// Assumes: every scl phase lasts at least 8 clocks
// Notes:   threshold is internal, so flag checks use boundary values
`timescale 1ns/1ps
`default_nettype none
module mrt_regs_chk
  import mrt_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       sclIn,
  input wire logic       sdaIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic       privilegedPasswordLevel,
  input wire logic [7:0] receivedPowerResultHi,
  input wire logic [7:0] tempSample,
  input wire logic [7:0] voltSample,
  input wire logic       sampleValid,
  input wire logic       warningFlag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_out_always_low: assert property (sdaOut == 1'b0) else $error("data output not low");
  a_oe_scl_low: assert property ($changed(sdaOe) |-> !sclIn) else $error("enable moved with scl high");
  a_oe_holds_high: assert property ($rose(sdaOe) |=> sdaOe [*8]) else $error("drive too short");
  a_oe_holds_low: assert property ($fell(sdaOe) |=> !sdaOe [*8]) else $error("release too short");
  a_idle_stays_silent: assert property ((sclIn && sdaIn && !sdaOe) [*8] |=> !sdaOe)
    else $error("drive on idle bus");
  a_warn_top_power: assert property (receivedPowerResultHi == 8'hFF |=> !warningFlag)
    else $error("flag with full power");
  a_warn_zero_power: assert property (
    receivedPowerResultHi == 8'h00 && $past(receivedPowerResultHi) == 8'h00 && !sdaOe && !$past(sdaOe)
    |=> $stable(warningFlag))
    else $error("flag moved at steady zero power");
  a_warn_has_cause: assert property ($changed(warningFlag) |->
    $past(receivedPowerResultHi) != $past(receivedPowerResultHi, 2) || $past(sdaOe) || $past(sdaOe, 2))
    else $error("flag moved without cause");
  c_ack: cover property ($rose(sdaOe));
  c_warn_on: cover property ($rose(warningFlag));
  c_warn_off: cover property ($fell(warningFlag));
endmodule
bind mrt_regs_top mrt_regs_chk u_chk (.core_clk(core_clk), .rst_n(rst_n), .sclIn(sclIn), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .privilegedPasswordLevel(privilegedPasswordLevel),
  .receivedPowerResultHi(receivedPowerResultHi), .tempSample(tempSample), .voltSample(voltSample),
  .sampleValid(sampleValid), .warningFlag(warningFlag));
`default_nettype wire

// file: shared/mrt_pkg.sv
// Purpose: constants and types for the monitor result and threshold byte slice
// Assumes: two-wire serial management bus, byte wide register map
// Notes:   every reset value below is zero
package mrt_pkg;
  localparam logic [6:0] DEV_ADDR        = 7'h51;
  localparam logic [7:0] OFF_RX_LOW_HI   = 8'h26;
  localparam logic [7:0] OFF_RX_LOW_LO   = 8'h27;
  localparam logic [7:0] OFF_CHECKSUM    = 8'h5F;
  localparam logic [7:0] OFF_TEMP_HI     = 8'h60;
  localparam logic [7:0] OFF_TEMP_LO     = 8'h61;
  localparam logic [7:0] OFF_VOLT_HI     = 8'h62;
  localparam logic [7:0] OFF_VOLT_LO     = 8'h63;
  localparam logic [7:0] RST_RX_LOW_HI   = 8'h00;
  localparam logic [7:0] RST_RX_LOW_LO   = 8'h00;
  localparam logic [7:0] RST_CHECKSUM    = 8'h00;
  localparam logic [7:0] RST_TEMP_HI     = 8'h00;
  localparam logic [7:0] RST_VOLT_HI     = 8'h00;
  localparam logic [7:0] LO_RESULT_VALUE = 8'h00;
  localparam logic [7:0] UNMAPPED_VALUE  = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
  localparam int unsigned SYNC_DEPTH     = 3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_TXACK
  } mrt_state_e;

  typedef enum logic [1:0] {
    PH_ADDR,
    PH_PTR,
    PH_DATA
  } mrt_phase_e;
endpackage

// file: shared/mrt_store_if.sv
// Purpose: carrier between the bus engine and the byte store
// Assumes: single clock, registered read data
// Notes:   address is the current byte pointer, or the latched write address during a write
`timescale 1ns/1ps
`default_nettype none
interface mrt_store_if;
  logic       wrEn;
  logic [7:0] addr;
  logic [7:0] wrData;
  logic [7:0] rdData;
  logic [7:0] threshHi;
  modport ctrl  (output wrEn, output addr, output wrData, input rdData, input threshHi);
  modport store (input wrEn, input addr, input wrData, output rdData, output threshHi);
endinterface
`default_nettype wire
